// file: include/pdwc_pkg.sv
// How it works
// - Configuration bit at one selects interruptible mode: pins govern entry and exit.
// - Interruptible entry needs every enabled fast interrupt pin at its inactive level.
// - Per-pin two-bit edge select; 00 disables the pin for entry and exit.
// - Select 01: rising edge, enter while low, wake while high.
// - Select 10: falling edge, enter while high, wake while low.
// - Select 11: any edge, never blocks entry, wake on any level change.
// - In power-down the clocks are frozen, oscillator and PLL stopped.
// - Interruptible mode exits on the reset pin or an enabled pin assertion.
// - While powered down the pins act as level-sensitive wake inputs.
// - Pin wake works regardless of that pin's interrupt enable bit.
// - Wake restarts oscillator and PLL, pulls delay pin down, resumes below threshold.
// - Waking pin with enabled interrupt gets its service routine after wake.
// - Waking pin with disabled interrupt leaves its request flag set for software.
// - The instruction after the power-down instruction runs before the service call.
// - Configuration bit zero: enter only with NMI low, leave only by hardware reset.
// - The system configuration register locks after the end-of-init instruction.
// - No entry while bus busy or while an enabled ready went unseen.
`default_nettype none
package pdwc_pkg;
    localparam int PDWC_PINS = 8;
    localparam logic [15:0] PDWC_EDGE_SEL_ADDR = 16'hF1C0;
    localparam logic [15:0] PDWC_EDGE_SEL_RESET = 16'h0000;
    localparam logic [15:0] PDWC_SYSCFG_RESET = 16'h0000;
    localparam int PDWC_CFG_BIT_POS = 5;
    localparam logic [1:0] PDWC_SEL_OFF = 2'h0;
    localparam logic [1:0] PDWC_SEL_RISE = 2'h1;
    localparam logic [1:0] PDWC_SEL_FALL = 2'h2;
    localparam logic [1:0] PDWC_SEL_ANY = 2'h3;
    localparam int PDWC_CLK_MHZ = 200;
    localparam int PDWC_WAKE_MIN_NS = 40;
    // Cycles a wake level must be seen; rounded down so a minimum pulse still wakes
    localparam int PDWC_WAKE_CYCLES = (PDWC_WAKE_MIN_NS * PDWC_CLK_MHZ) / 1000;
    typedef enum logic [1:0] {PDWC_RUN, PDWC_DOWN, PDWC_DELAY} pdwc_state_type;
endpackage
`default_nettype wire

// file: include/pdwc_wake_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pdwc_wake_if;
    logic [15:0] edge_sel;
    logic [7:0] pins;
    logic [7:0] ref_level;
    logic [7:0] inactive;
    logic [7:0] wake;
    modport ctrl (output edge_sel, output pins, output ref_level, input inactive, input wake);
    modport det (input edge_sel, input pins, input ref_level, output inactive, output wake);
endinterface
`default_nettype wire

// file: design/pdwc_wake_detect.sv
`timescale 1ns/1ps
`default_nettype none
module pdwc_wake_detect (
    pdwc_wake_if.det w
);
    import pdwc_pkg::*;
    genvar i;
    generate
        for (i = 0; i < PDWC_PINS; i++) begin : g_pin
            logic [1:0] sel;
            assign sel = w.edge_sel[2*i+1:2*i];
            // Entry permission per pin: off and any-edge never block
            assign w.inactive[i] = (sel == PDWC_SEL_OFF) ||
                (sel == PDWC_SEL_ANY) ||
                ((sel == PDWC_SEL_RISE) && !w.pins[i]) ||
                ((sel == PDWC_SEL_FALL) && w.pins[i]);
            // Level-sensitive wake request, enable bit not consulted
            assign w.wake[i] =
                ((sel == PDWC_SEL_RISE) && w.pins[i]) ||
                ((sel == PDWC_SEL_FALL) && !w.pins[i]) ||
                ((sel == PDWC_SEL_ANY) && (w.pins[i] != w.ref_level[i]));
        end
    endgenerate
endmodule
`default_nettype wire

// file: design/pdwc_power_down_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module pdwc_power_down_ctrl (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic reg_wr,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic syscfg_wr,
    input wire logic [15:0] syscfg_wdata,
    output logic [15:0] system_config_reg,
    input wire logic end_init_instruction,
    input wire logic power_down_instruction,
    input wire logic nmi_n,
    input wire logic bus_idle,
    input wire logic ready_enabled,
    input wire logic ready_seen,
    input wire logic [pdwc_pkg::PDWC_PINS-1:0] fast_ext_irq_pin,
    input wire logic [pdwc_pkg::PDWC_PINS-1:0] irq_enable_bit,
    input wire logic reset_input_pin_n,
    input wire logic wake_delay_done,
    output logic clk_gate_en,
    output logic osc_pll_run,
    output logic wake_delay_pulldown,
    output logic powered_down,
    output logic [pdwc_pkg::PDWC_PINS-1:0] irq_request_set,
    output logic [pdwc_pkg::PDWC_PINS-1:0] irq_service_req
);
    import pdwc_pkg::*;

    pdwc_wake_if w ();
    pdwc_wake_detect u_det (
        .w(w)
    );

    logic [15:0] ext_irq_edge_select;
    logic init_done;
    logic [7:0] ref_level;
    logic [7:0] pin_held;
    logic [7:0] wake_seen;
    logic [7:0] hold_cnt [PDWC_PINS];
    pdwc_state_type state;
    logic power_down_cfg_flag;
    logic entry_ok;
    logic pin_wake;

    assign power_down_cfg_flag = system_config_reg[PDWC_CFG_BIT_POS];
    assign w.edge_sel = ext_irq_edge_select;
    assign w.pins = fast_ext_irq_pin;
    assign w.ref_level = ref_level;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ext_irq_edge_select <= PDWC_EDGE_SEL_RESET;
        end else if (clk_en && reg_wr && reg_addr == PDWC_EDGE_SEL_ADDR) begin
            ext_irq_edge_select <= reg_wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            system_config_reg <= PDWC_SYSCFG_RESET;
            init_done <= 1'b0;
        end else if (clk_en) begin
            if (syscfg_wr && !init_done) begin
                system_config_reg <= syscfg_wdata;
            end
            if (end_init_instruction) begin
                init_done <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (clk_en) begin
            reg_rdata <= (reg_addr == PDWC_EDGE_SEL_ADDR) ? ext_irq_edge_select : 16'h0000;
        end
    end

    // ----------------------------------------
    // Entry decision
    // ----------------------------------------
    always_comb begin
        if (power_down_cfg_flag) begin
            entry_ok = &w.inactive;
        end else begin
            entry_ok = !nmi_n;
        end
        entry_ok = entry_ok && bus_idle && (!ready_enabled || ready_seen);
    end

    // ----------------------------------------
    // Pin wake qualification: pulse must last the minimum width
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < PDWC_PINS; i++) begin : g_hold
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    hold_cnt[i] <= 8'h00;
                end else if (clk_en) begin
                    if (state != PDWC_DOWN || !w.wake[i]) begin
                        hold_cnt[i] <= 8'h00;
                    end else if (hold_cnt[i] < 8'(PDWC_WAKE_CYCLES)) begin
                        hold_cnt[i] <= hold_cnt[i] + 8'h01;
                    end
                end
            end
            assign pin_held[i] = w.wake[i] &&
                (hold_cnt[i] >= 8'(PDWC_WAKE_CYCLES - 1));
        end
    endgenerate

    assign pin_wake = power_down_cfg_flag && (|pin_held);

    // ----------------------------------------
    // Power state
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= PDWC_RUN;
            ref_level <= 8'h00;
            wake_seen <= 8'h00;
        end else if (clk_en) begin
            unique case (state)
                PDWC_RUN: begin
                    if (power_down_instruction && entry_ok) begin
                        state <= PDWC_DOWN;
                        ref_level <= fast_ext_irq_pin;
                        wake_seen <= 8'h00;
                    end
                end
                PDWC_DOWN: begin
                    if (!reset_input_pin_n) begin
                        state <= PDWC_DELAY;
                    end else if (pin_wake) begin
                        state <= PDWC_DELAY;
                        wake_seen <= pin_held;
                    end
                end
                PDWC_DELAY: begin
                    if (wake_delay_done) begin
                        state <= PDWC_RUN;
                    end
                end
            endcase
        end
    end

    assign clk_gate_en = (state == PDWC_RUN);
    assign osc_pll_run = (state != PDWC_DOWN);
    assign wake_delay_pulldown = (state == PDWC_DELAY);
    assign powered_down = (state != PDWC_RUN);

    // ----------------------------------------
    // Wake hand-off to interrupt logic
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_request_set <= 8'h00;
            irq_service_req <= 8'h00;
        end else if (clk_en) begin
            irq_request_set <= 8'h00;
            irq_service_req <= 8'h00;
            if (state == PDWC_DELAY && wake_delay_done) begin
                irq_request_set <= wake_seen;
                irq_service_req <= wake_seen & irq_enable_bit;
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    clocks_frozen_a: assert property (
        state == PDWC_DOWN |-> !clk_gate_en && !osc_pll_run)
        else $error("clocks running in power down");
    entry_gate_a: assert property (
        clk_en && state == PDWC_RUN && power_down_instruction && !entry_ok
        |=> state == PDWC_RUN)
        else $error("entry taken while blocked");
    nmi_entry_a: assert property (
        clk_en && state == PDWC_RUN && power_down_instruction && !power_down_cfg_flag && nmi_n
        |=> state == PDWC_RUN)
        else $error("protected entry without nmi");
    protected_exit_a: assert property (
        clk_en && state == PDWC_DOWN && !power_down_cfg_flag && reset_input_pin_n
        |=> state == PDWC_DOWN)
        else $error("protected mode left without reset");
    reset_exit_a: assert property (
        clk_en && state == PDWC_DOWN && !reset_input_pin_n
        |=> wake_delay_pulldown && osc_pll_run)
        else $error("reset did not start wake");
    idle_pins_a: assert property (
        state == PDWC_DOWN && power_down_cfg_flag && reset_input_pin_n && w.wake == 8'h00
        |=> state == PDWC_DOWN)
        else $error("wake without an enabled pin at its wake level");
    delay_hold_a: assert property (
        state == PDWC_DELAY && !wake_delay_done |=> !clk_gate_en)
        else $error("clocks released before delay");
    lock_cfg_a: assert property (
        init_done && syscfg_wr |=> $stable(system_config_reg))
        else $error("config written after init");
    bus_busy_a: assert property (state == PDWC_RUN && !bus_idle |=> state == PDWC_RUN)
        else $error("entry with bus busy");
    service_mask_a: assert property (
        (irq_service_req & ~irq_request_set) == 8'h00 &&
        (!$rose(|irq_request_set) || $past(state == PDWC_DELAY)))
        else $error("service without request");

    enter_c: cover property (state == PDWC_RUN ##1 state == PDWC_DOWN);
    pin_wake_c: cover property (state == PDWC_DOWN && pin_wake);
    resume_c: cover property (state == PDWC_DELAY ##1 state == PDWC_RUN);
    service_c: cover property (|irq_service_req);
endmodule
`default_nettype wire

// file: verif/pdwc_rc_delay_model.sv
`timescale 1ns/1ps
`default_nettype none
module pdwc_rc_delay_model #(
    parameter int DELAY_CYCLES = 12
) (
    input wire logic clk_sys,
    input wire logic wake_delay_pulldown,
    output logic wake_delay_done
);
    int count = 0;
    // ----------------------------------------
    // Capacitor discharge through the weak pull-down
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!wake_delay_pulldown) begin
            count <= 0;
        end else if (count < DELAY_CYCLES) begin
            count <= count + 1;
        end
    end
    // Threshold crossed only after a full discharge time
    assign wake_delay_done = wake_delay_pulldown && (count >= DELAY_CYCLES);
endmodule
`default_nettype wire

// file: verif/power_down_wakeup_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module power_down_wakeup_control_bench;
    import pdwc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic syscfg_wr = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] syscfg_wdata = 16'h0000;
    logic end_init_instruction = 1'b0;
    logic power_down_instruction = 1'b0;
    logic clk_en = 1'b1;
    logic nmi_n = 1'b1;
    logic bus_idle = 1'b1;
    logic ready_enabled = 1'b0;
    logic ready_seen = 1'b0;
    logic reset_input_pin_n = 1'b1;
    logic [7:0] fast_ext_irq_pin = 8'h00;
    logic [7:0] irq_enable_bit = 8'h00;
    logic [15:0] reg_rdata, system_config_reg;
    logic [7:0] irq_request_set, irq_service_req;
    logic wake_delay_done, clk_gate_en, osc_pll_run, wake_delay_pulldown, powered_down;
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;

    pdwc_power_down_ctrl pdwc_power_down_ctrl_inst (
        .clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .syscfg_wr(syscfg_wr),
        .syscfg_wdata(syscfg_wdata), .system_config_reg(system_config_reg),
        .end_init_instruction(end_init_instruction), .nmi_n(nmi_n), .bus_idle(bus_idle),
        .power_down_instruction(power_down_instruction), .ready_enabled(ready_enabled),
        .ready_seen(ready_seen), .fast_ext_irq_pin(fast_ext_irq_pin),
        .irq_enable_bit(irq_enable_bit), .reset_input_pin_n(reset_input_pin_n),
        .wake_delay_done(wake_delay_done), .clk_gate_en(clk_gate_en),
        .osc_pll_run(osc_pll_run), .wake_delay_pulldown(wake_delay_pulldown),
        .powered_down(powered_down), .irq_request_set(irq_request_set),
        .irq_service_req(irq_service_req)
    );
    pdwc_rc_delay_model pdwc_rc_delay_model_inst (
        .clk_sys(clk_sys), .wake_delay_pulldown(wake_delay_pulldown),
        .wake_delay_done(wake_delay_done)
    );

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wr_sel(input logic [15:0] data);
        reg_wr = 1'b1;
        reg_addr = PDWC_EDGE_SEL_ADDR;
        reg_wdata = data;
        tick(1);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] addr, input logic [15:0] exp);
        reg_addr = addr;
        tick(1);
        check("reg_rdata", reg_rdata, exp);
    endtask
    task automatic cfg_wr(input logic [15:0] data, input logic [15:0] exp);
        syscfg_wr = 1'b1;
        syscfg_wdata = data;
        tick(1);
        syscfg_wr = 1'b0;
        tick(1);
        check("system_config_reg", system_config_reg, exp);
    endtask
    // Request power-down and check whether it was taken
    task automatic pd(input logic enter);
        power_down_instruction = 1'b1;
        tick(1);
        power_down_instruction = 1'b0;
        tick(1);
        check("clk_gate_en", 16'(clk_gate_en), 16'(!enter));
        check("powered_down", 16'(powered_down), 16'(enter));
    endtask
    task automatic wait_resume(input logic [7:0] set_exp, input logic [7:0] svc_exp);
        check("wake_delay_pulldown", 16'(wake_delay_pulldown), 16'h0001);
        check("osc_pll_run", 16'(osc_pll_run), 16'h0001);
        for (int i = 0; i < 100 && clk_gate_en !== 1'b1; i++) begin
            tick(1);
        end
        check("clk_gate_en", 16'(clk_gate_en), 16'h0001);
        check("irq_request_set", 16'(irq_request_set), 16'(set_exp));
        check("irq_service_req", 16'(irq_service_req), 16'(svc_exp));
    endtask
    task automatic reset_wake;
        reset_input_pin_n = 1'b0;
        tick(6);
        reset_input_pin_n = 1'b1;
        wait_resume(8'h00, 8'h00);
    endtask
    // Any-edge pins enter at their current level and wake on the opposite one
    task automatic pin_cycle(input int idx, input logic [1:0] sel, input logic idle,
                             input logic en);
        wr_sel(16'(sel) << (2 * idx));
        irq_enable_bit = 8'(en) << idx;
        fast_ext_irq_pin[idx] = !idle;
        tick(1);
        if (sel != PDWC_SEL_ANY) begin
            pd(1'b0);
            fast_ext_irq_pin[idx] = idle;
        end
        pd(1'b1);
        fast_ext_irq_pin[idx] = !fast_ext_irq_pin[idx];
        tick(10);
        check("clk_gate_en", 16'(clk_gate_en), 16'h0000);
        wait_resume(8'h01 << idx, 8'(en) << idx);
    endtask

    // ----------------------------------------
    // Clock, reset and timeout
    // ----------------------------------------
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            summarize();
        end
    end

    initial begin
        tick(20);
        rst = 1'b0;
        rd(PDWC_EDGE_SEL_ADDR, PDWC_EDGE_SEL_RESET);
        check("system_config_reg", system_config_reg, PDWC_SYSCFG_RESET);
        wr_sel(16'hA5C3);
        rd(PDWC_EDGE_SEL_ADDR, 16'hA5C3);
        rd(16'hF1C2, 16'h0000);
        // Pins enabled at their wake level must not end protected power-down
        wr_sel(16'h5555);
        pd(1'b0);
        nmi_n = 1'b0;
        pd(1'b1);
        nmi_n = 1'b1;
        fast_ext_irq_pin = 8'hFF;
        // A frozen block ignores the reset pin
        clk_en = 1'b0;
        reset_input_pin_n = 1'b0;
        tick(3);
        check("osc_pll_run", 16'(osc_pll_run), 16'h0000);
        clk_en = 1'b1;
        reset_input_pin_n = 1'b1;
        tick(10);
        check("osc_pll_run", 16'(osc_pll_run), 16'h0000);
        reset_wake();
        fast_ext_irq_pin = 8'h00;
        wr_sel(16'h0000);
        cfg_wr(16'h0020, 16'h0020);
        bus_idle = 1'b0;
        pd(1'b0);
        bus_idle = 1'b1;
        ready_enabled = 1'b1;
        pd(1'b0);
        ready_seen = 1'b1;
        pd(1'b1);
        fast_ext_irq_pin = 8'hFF;
        tick(10);
        check("powered_down", 16'(powered_down), 16'h0001);
        reset_wake();
        fast_ext_irq_pin = 8'h00;
        end_init_instruction = 1'b1;
        tick(1);
        end_init_instruction = 1'b0;
        cfg_wr(16'h0000, 16'h0020);
        pin_cycle(0, PDWC_SEL_RISE, 1'b0, 1'b1);
        pin_cycle(3, PDWC_SEL_FALL, 1'b1, 1'b0);
        pin_cycle(5, PDWC_SEL_ANY, 1'b1, 1'b1);
        pin_cycle(7, PDWC_SEL_ANY, 1'b0, 1'b0);
        summarize();
    end
endmodule
`default_nettype wire
